// ---- core/bitproc_pkg.sv ----
// Constants, op-codes and carrier types of the one-bit control processor.
// Assumes one 20 MHz clock and an external program memory and selectors.
// Overview of operation
// [RULE1] Fetch, execute, next address, forever
// [RULE2] Four-bit op-code picks one of sixteen
// [RULE3] Memory gives op-code and operand address together
// [RULE4] Load samples data line into result_bit
// [RULE5] Store drives result_bit onto data line
// [RULE6] Store raises write strobe for latches
// [RULE7] Write strobe latches data at given address
// [RULE8] Selector puts addressed input on line
// [RULE9] AND combines result_bit with data line
// [RULE10] Program counter counts up and wraps
// [RULE11] Moves and logic use one-bit data line
// [RULE12] One command completes every clock period; stores drive a period late, load and AND see the line two periods late
package bitproc_pkg;
  localparam int OP_W = 4;
  localparam int OP_COUNT = 16;
  typedef logic [OP_W-1:0] opcode_t;
  localparam opcode_t OP_NOP = 4'h0;
  localparam opcode_t OP_LOAD = 4'h1;
  localparam opcode_t OP_AND = 4'h3;
  localparam opcode_t OP_STORE = 4'h8;
  localparam logic RESULT_RST = 1'b0;
  localparam int ADDR_W_DEF = 8;

  // Data line pin seen from the processor
  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic write_stb;
  } bus_drive_s;
endpackage : bitproc_pkg

// ---- core/op_decode.sv ----
// Op-code decoder of the one-bit control processor.
// Assumes the op-code is stable from program memory for the whole clock period.
`timescale 1ns/10ps
module op_decode (
  input wire bitproc_pkg::opcode_t opcode, // Op-code from memory
  output logic is_load, // Load command
  output logic is_and, // AND command
  output logic is_store // Store command
);
  import bitproc_pkg::*;
  always_comb begin
    is_load = 1'b0;
    is_and = 1'b0;
    is_store = 1'b0;
    unique case (opcode) // RULE2
      OP_LOAD: is_load = 1'b1;
      OP_AND: is_and = 1'b1;
      OP_STORE: is_store = 1'b1;
      default: ; // Other codes are no-ops in this block
    endcase
  end
endmodule : op_decode

// ---- core/one_bit_processor.sv ----
// One-bit control processor: result_bit, data line drive and write strobe.
// Assumes memory presents op-code and operand address each clock period.
`timescale 1ns/10ps
module one_bit_processor (
  input wire logic clk, // 20 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input wire bitproc_pkg::opcode_t opcode, // Op-code from program memory
  input wire logic data_in, // Data line level from input selectors
  output logic data_out, // Data line value driven for stores
  output logic data_oe, // High while the processor drives the data line
  output logic write_stb, // Write strobe to output latches
  output logic result_bit // Result register
);
  import bitproc_pkg::*;

  // Decoder and memory word layout both assume sixteen codes on four bits
  if ($bits(opcode_t) != OP_W || OP_COUNT != (1 << OP_W)) begin : g_bad_opcode
    $error("op-code width does not match the op-code count");
  end

  logic is_load;
  logic is_and;
  logic is_store;
  logic din_meta_q;
  logic din_sync_q;
  logic result_q;
  logic result_d;
  bus_drive_s drive_q;
  bus_drive_s drive_d;

  op_decode u_dec (
    .opcode(opcode),
    .is_load(is_load),
    .is_and(is_and),
    .is_store(is_store)
  );

  // Data line comes from pins; two stages before use. Costs two cycles of latency
  // on input sampling, so selectors must hold their level accordingly.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_meta_q <= 1'b0;
      din_sync_q <= 1'b0;
    end else begin
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  always_comb begin
    result_d = result_q;
    if (is_load) begin
      result_d = din_sync_q; // RULE4 RULE11
    end else if (is_and) begin
      result_d = result_q & din_sync_q; // RULE9 RULE11
    end
  end

  // One command per clock: every edge executes the presented op-code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= RESULT_RST;
    end else begin
      result_q <= result_d; // RULE1 RULE12
    end
  end

  always_comb begin
    drive_d.data_out = result_q; // RULE5
    drive_d.data_oe = is_store; // RULE5 RULE11
    drive_d.write_stb = is_store; // RULE6
  end

  // Outputs leave flip-flops, so the strobe comes one cycle after the store word;
  // memory must keep the latch address on for that extra cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  assign data_out = drive_q.data_out;
  assign data_oe = drive_q.data_oe;
  assign write_stb = drive_q.write_stb;
  assign result_bit = result_q;

  property p_load;
    @(posedge clk) disable iff (rst) is_load |=> result_q == $past(din_sync_q);
  endproperty
  a_load: assert property (p_load) else $error("load did not capture data"); // RULE4

  property p_and;
    @(posedge clk) disable iff (rst)
      is_and |=> result_q == ($past(result_q) & $past(din_sync_q));
  endproperty
  a_and: assert property (p_and) else $error("AND result wrong"); // RULE9

  sequence s_store;
    is_store;
  endsequence
  property p_store_drive;
    @(posedge clk) disable iff (rst)
      s_store |=> data_oe && data_out == $past(result_q);
  endproperty
  a_store_drive: assert property (p_store_drive) else $error("store drive wrong"); // RULE5

  property p_store_write;
    @(posedge clk) disable iff (rst) s_store |=> write_stb;
  endproperty
  a_store_write: assert property (p_store_write) else $error("no write strobe"); // RULE6

  property p_write_only_store;
    @(posedge clk) disable iff (rst) write_stb |-> $past(is_store) && data_oe;
  endproperty
  a_write_only_store: assert property (p_write_only_store) // RULE6
    else $error("stray write strobe");

  property p_hold;
    @(posedge clk) disable iff (rst) !is_load && !is_and |=> $stable(result_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed"); // RULE12

  property p_oe_release;
    @(posedge clk) disable iff (rst) !is_store |=> !data_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("line not released"); // RULE11

  property p_one_hot_dec;
    @(posedge clk) disable iff (rst) $onehot0({is_load, is_and, is_store});
  endproperty
  a_one_hot_dec: assert property (p_one_hot_dec) else $error("decode clash"); // RULE2

  // A load or AND sees the line two edges late; these walks check the whole path
  // from the pin through the synchroniser into result_bit, not only the last stage.
  sequence s_line_high;
    (!rst && data_in) ##1 data_in;
  endsequence

  sequence s_line_low;
    (!rst && !data_in) ##1 !data_in;
  endsequence

  property p_load_high;
    @(posedge clk) disable iff (rst)
      s_line_high ##1 is_load
      |=> result_q;
  endproperty
  a_load_high: assert property (p_load_high) else $error("load lost a high line"); // RULE4

  property p_load_low;
    @(posedge clk) disable iff (rst)
      s_line_low ##1 is_load
      |=> !result_q;
  endproperty
  a_load_low: assert property (p_load_low) else $error("load lost a low line"); // RULE4

  property p_and_low;
    @(posedge clk) disable iff (rst)
      s_line_low ##1 is_and
      |=> !result_q;
  endproperty
  a_and_low: assert property (p_and_low) else $error("AND passed a low line"); // RULE9

  property p_and_pass;
    @(posedge clk) disable iff (rst)
      s_line_high ##1 (is_and && result_q)
      |=> result_q;
  endproperty
  a_and_pass: assert property (p_and_pass) else $error("AND lost a true result"); // RULE9

  property p_and_block;
    @(posedge clk) disable iff (rst)
      s_line_high ##1 (is_and && !result_q)
      |=> !result_q;
  endproperty
  a_and_block: assert property (p_and_block) else $error("AND raised a false result"); // RULE9

  // Strobe and drive leave one decode, so a latch never takes an undriven line
  property p_oe_with_strobe;
    @(posedge clk) disable iff (rst)
      data_oe == write_stb;
  endproperty
  a_oe_with_strobe: assert property (p_oe_with_strobe) else $error("strobe alone"); // RULE6

  property p_strobe_release;
    @(posedge clk) disable iff (rst)
      !is_store
      |=> !write_stb;
  endproperty
  a_strobe_release: assert property (p_strobe_release) else $error("strobe stuck"); // RULE6

  property p_out_matches;
    @(posedge clk) disable iff (rst)
      data_oe
      |-> data_out == result_q;
  endproperty
  a_out_matches: assert property (p_out_matches) else $error("driven bit not result"); // RULE5

  // A lone store gives one strobe cycle; back-to-back stores merge into one pulse
  sequence s_lone_store;
    is_store ##1 !is_store;
  endsequence

  property p_strobe_pulse;
    @(posedge clk) disable iff (rst)
      s_lone_store
      |-> write_stb ##1 !write_stb;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe width wrong"); // RULE6

  property p_store_keeps;
    @(posedge clk) disable iff (rst)
      s_store
      |=> $stable(result_q);
  endproperty
  a_store_keeps: assert property (p_store_keeps) else $error("store moved result"); // RULE5

  property p_other_quiet;
    @(posedge clk) disable iff (rst)
      !is_load && !is_and && !is_store
      |=> $stable(result_q) && !write_stb;
  endproperty
  a_other_quiet: assert property (p_other_quiet) else $error("no-op had an effect"); // RULE2
endmodule : one_bit_processor

// ---- verification/ctl_env.sv ----
// Partner model: program counter, program memory, input selector, latches.
// Assumes the processor shares its clock and reset.
`timescale 1ns/10ps
module ctl_env (
  input wire logic clk, // System clock
  input wire logic rst, // Reset, active high
  input wire logic [1:0] ins, // Input pins
  input wire bitproc_pkg::bus_drive_s drv, // Processor pin drive
  output bitproc_pkg::opcode_t opcode, // Op-code to processor
  output logic line, // Data line level
  output logic [3:0] latch_q // Output latches
);
  import bitproc_pkg::*;
  // Addresses held two words ahead of load and AND to cover the input synchroniser
  function automatic logic [5:0] prog_word(input logic [2:0] a);
    case (a)
      3'h2: prog_word = 6'h04;
      3'h3, 3'h4: prog_word = 6'h01;
      3'h5: prog_word = 6'h0D;
      3'h6: prog_word = 6'h22;
      3'h7: prog_word = 6'h02;
      default: prog_word = 6'h00;
    endcase
  endfunction : prog_word
  logic [2:0] pc_q;
  logic [5:0] word;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pc_q <= 3'h0;
    else pc_q <= pc_q + 3'h1;
  end
  assign word = prog_word(pc_q);
  assign opcode = word[5:2];
  assign line = drv.data_oe ? drv.data_out : ins[word[0]];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) latch_q <= 4'h0;
    else if (drv.write_stb) latch_q[word[1:0]] <= line;
  end
endmodule : ctl_env

// ---- verification/tb_top.sv ----
// Self-checking bench for the one-bit processor.
// Assumes the partner model runs a fixed AND-and-store program.
`timescale 1ns/10ps
module tb_top;
  import bitproc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] ins = 2'h0;
  logic d_out, d_oe, w_stb, res, line;
  opcode_t opcode;
  bus_drive_s drv;
  logic [3:0] latch_q;
  int miscompares = 0;
  int samples_checked = 0;
  int strobes = 0;
  logic [2:0] rows [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
  always #25 clk = ~clk;
  assign drv = '{data_out: d_out, data_oe: d_oe, write_stb: w_stb};
  ctl_env env (.clk(clk), .rst(rst), .ins(ins), .drv(drv), .opcode(opcode), .line(line),
    .latch_q(latch_q));
  one_bit_processor dut (.clk(clk), .rst(rst), .opcode(opcode), .data_in(line),
    .data_out(d_out), .data_oe(d_oe), .write_stb(w_stb), .result_bit(res));
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // The run needs about 220 clocks; 2000 leaves a wide margin
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    check({d_oe, w_stb, res, latch_q[2]}, 4'h0);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      ins <= rows[i][2:1];
      repeat (24) @(posedge clk);
      @(negedge clk);
      while (opcode !== OP_STORE) @(negedge clk);
      check({3'h0, res}, {3'h0, rows[i][0]});
      repeat (3) @(negedge clk);
      check(latch_q, {1'b0, rows[i][0], 2'h0});
    end
    // Eight words a loop, so one store per eight clocks
    repeat (64) begin
      @(negedge clk);
      strobes += w_stb;
    end
    check(strobes[3:0], 4'h8);
    // Reset in mid-run: result and latches clear, then the program starts over
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    check({d_oe, w_stb, res, latch_q[2]}, 4'h0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check({d_oe, w_stb, res, latch_q[2]}, 4'h0);
    while (opcode !== OP_STORE) @(negedge clk);
    check({3'h0, res}, 4'h1);
    repeat (3) @(negedge clk);
    check(latch_q, 4'h4);
    summarize();
  end
endmodule : tb_top
